/* File: sso_host_model.sv */
// Host controller model that raises servo-on once the drive reports ready and holds it until want_on drops
module sso_host_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Host intent and drive status
  input  wire logic want_on,
  input  wire logic servo_ready,
  // Command to the drive
  output logic      servo_on_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic son_r;
  logic son_nxt;
  always_comb begin
    son_nxt = son_r;
    if (!want_on) son_nxt = 1'b0;
    else if (servo_ready) son_nxt = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) son_r <= 1'b0;
    else son_r <= son_nxt;
  end
  assign servo_on_cmd = son_r;
endmodule

/* File: sso_pkg.sv */
// Package: register map, reset values and field layout for the servo status outputs
package sso_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ROT_THR   = 8'h04;
  localparam logic [7:0] OFS_POSITIONING_COMPLETE_WIN  = 8'h08;
  localparam logic [7:0] OFS_CMPL_W    = 8'h0C;
  localparam logic [7:0] OFS_NEAR_W    = 8'h10;
  localparam logic [7:0] OFS_QUAL      = 8'h14;
  localparam logic [7:0] OFS_ALLOC_A   = 8'h18;
  localparam logic [7:0] OFS_ALLOC_B   = 8'h1C;
  localparam logic [7:0] OFS_STATUS    = 8'h20;
  // Reset values
  localparam logic [13:0] RST_ROT_THR  = 14'h0014;
  localparam logic [6:0]  RST_POSITIONING_COMPLETE_WIN = 7'h0A;
  localparam logic [30:0] RST_CMPL_W   = 31'h0000000A;
  localparam logic [30:0] RST_NEAR_W   = 31'h40000000;
  localparam logic [1:0]  RST_QUAL     = 2'h0;
  localparam logic [15:0] RST_ALLOC_A  = 16'h0000;
  localparam logic [15:0] RST_ALLOC_B  = 16'h0000;
  // Caps of the threshold ranges
  localparam logic [13:0] MAX_ROT_THR  = 14'h2710;
  localparam logic [6:0]  MAX_POSITIONING_COMPLETE_WIN = 7'h64;
  localparam logic [30:0] MAX_WIDTH    = 31'h40000000;
  // Allocation digit positions (4-bit digits)
  localparam int DIG_POSITIONING_COMPLETE  = 0;
  localparam int DIG_VCMP  = 4;
  localparam int DIG_RDY   = 8;
  localparam int DIG_ROTATION_DETECTED  = 12;
  localparam int DIG_NEAR  = 0;
  // Allocation digit value meaning "not allocated"
  localparam logic [3:0] ALLOC_NONE = 4'h0;
  // Status register bit positions
  localparam int ST_ROT  = 0;
  localparam int ST_RDY  = 1;
  localparam int ST_VCMP = 2;
  localparam int ST_POSITIONING_COMPLETE = 3;
  localparam int ST_NEAR = 4;
  localparam int ST_POLE = 5;
  typedef enum logic [1:0] {QUAL_DEV, QUAL_FILT, QUAL_RAW} sso_qual_t;
  typedef enum {PD_IDLE, PD_RUN, PD_DONE} sso_pole_t;
endpackage

/* File: sso_status.sv */
// Servo drive status indications with APB-accessible thresholds and output allocation
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module sso_status #(
  parameter int SPD_W = 16,
  parameter int POS_W = 32,
  parameter int N_OUT = 8
) (
  // APB
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Drive state, same clock
  input  wire logic signed [SPD_W-1:0] motor_speed,
  input  wire logic signed [SPD_W-1:0] cmd_speed,
  input  wire logic signed [POS_W-1:0] pos_deviation,
  input  wire logic                    filt_cmd_zero,
  input  wire logic                    raw_cmd_zero,
  input  wire logic                    speed_mode,
  input  wire logic                    position_mode,
  input  wire logic                    main_power_on,
  input  wire logic                    base_block,
  input  wire logic                    alarm_active,
  input  wire logic                    abs_encoder,
  input  wire logic                    sensor_on_cmd,
  input  wire logic                    abs_data_sent,
  input  wire logic                    servo_on_cmd,
  input  wire logic                    pole_det_done,
  // Indications
  output logic                         pole_det_start,
  output logic                         rotation_detected,
  output logic                         servo_ready,
  output logic                         speed_coincidence,
  output logic                         positioning_complete,
  output logic                         near_position,
  output logic      [N_OUT-1:0]        out_contact
);
  timeunit 1ns;
  timeprecision 1ns;

  function automatic logic [POS_W-1:0] mag(input logic signed [POS_W-1:0] v);
    mag = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
  endfunction

  // Route one indication through a 4-bit allocation digit (1..N_OUT selects terminal)
  function automatic logic [N_OUT-1:0] route(input logic [3:0] dig, input logic ind);
    logic [N_OUT-1:0] m;
    m = '0;
    if (dig != sso_pkg::ALLOC_NONE && int'(dig) <= N_OUT) begin
      m[int'(dig) - 1] = ind;
    end
    route = m;
  endfunction

  // Configuration registers
  logic [13:0] rot_thr_r,   rot_thr_nxt;
  logic [6:0]  positioning_complete_win_r,  positioning_complete_win_nxt;
  logic [30:0] cmpl_w_r,    cmpl_w_nxt;
  logic [30:0] near_w_r,    near_w_nxt;
  logic [1:0]  qual_r,      qual_nxt;
  logic [15:0] alloc_a_r,   alloc_a_nxt;
  logic [15:0] alloc_b_r,   alloc_b_nxt;
  logic [31:0] prdata_r,    prdata_nxt;
  logic        pready_r,    pready_nxt;
  logic        pslverr_r,   pslverr_nxt;

  // Registered drive inputs
  logic signed [SPD_W-1:0] mspd_r, cspd_r;
  logic signed [POS_W-1:0] dev_r;
  logic                    fz_r, rz_r, smode_r, pmode_r;

  // Indication and pole-detection state
  sso_pkg::sso_pole_t pole_r, pole_nxt;
  logic        rot_r,  rot_nxt;
  logic        rdy_r,  rdy_nxt;
  logic        vcmp_r, vcmp_nxt;
  logic        positioning_complete_r, positioning_complete_nxt;
  logic        near_r, near_nxt;
  logic        pstart_r, pstart_nxt;
  logic [N_OUT-1:0] cont_r, cont_nxt;

  logic        acc;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_en;
  logic [SPD_W:0]   sdiff;
  logic [SPD_W:0]   sdiff_abs;
  logic [SPD_W-1:0] mspd_abs;
  logic [POS_W-1:0] dev_abs;

  assign acc = psel & penable & ~pready_r;
  // Writes commit on the edge where the master samples pready high
  assign wr_en = psel & penable & pready_r & pwrite & rd_ok;

  // Register read decode
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (paddr)
      sso_pkg::OFS_CTRL:     rd_val = 32'h00000000;
      sso_pkg::OFS_ROT_THR:  rd_val = {18'h00000, rot_thr_r};
      sso_pkg::OFS_POSITIONING_COMPLETE_WIN: rd_val = {25'h0000000, positioning_complete_win_r};
      sso_pkg::OFS_CMPL_W:   rd_val = {1'b0, cmpl_w_r};
      sso_pkg::OFS_NEAR_W:   rd_val = {1'b0, near_w_r};
      sso_pkg::OFS_QUAL:     rd_val = {30'h00000000, qual_r};
      sso_pkg::OFS_ALLOC_A:  rd_val = {16'h0000, alloc_a_r};
      sso_pkg::OFS_ALLOC_B:  rd_val = {16'h0000, alloc_b_r};
      sso_pkg::OFS_STATUS: begin
        rd_val[sso_pkg::ST_ROT]  = rot_r;
        rd_val[sso_pkg::ST_RDY]  = rdy_r;
        rd_val[sso_pkg::ST_VCMP] = vcmp_r;
        rd_val[sso_pkg::ST_POSITIONING_COMPLETE] = positioning_complete_r;
        rd_val[sso_pkg::ST_NEAR] = near_r;
        rd_val[sso_pkg::ST_POLE] = (pole_r == sso_pkg::PD_DONE);
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // APB writes; out-of-range thresholds saturate at the top of their range
  always_comb begin
    rot_thr_nxt  = rot_thr_r;
    positioning_complete_win_nxt = positioning_complete_win_r;
    cmpl_w_nxt   = cmpl_w_r;
    near_w_nxt   = near_w_r;
    qual_nxt     = qual_r;
    alloc_a_nxt  = alloc_a_r;
    alloc_b_nxt  = alloc_b_r;
    pready_nxt   = acc;
    pslverr_nxt  = acc & ~rd_ok;
    prdata_nxt   = (acc && !pwrite) ? rd_val : 32'h00000000;
    if (wr_en) begin
      case (paddr)
        sso_pkg::OFS_ROT_THR:
          rot_thr_nxt = (pwdata > 32'(sso_pkg::MAX_ROT_THR)) ? sso_pkg::MAX_ROT_THR
                                                             : pwdata[13:0];
        sso_pkg::OFS_POSITIONING_COMPLETE_WIN:
          positioning_complete_win_nxt = (pwdata > 32'(sso_pkg::MAX_POSITIONING_COMPLETE_WIN)) ? sso_pkg::MAX_POSITIONING_COMPLETE_WIN
                                                               : pwdata[6:0];
        sso_pkg::OFS_CMPL_W:
          cmpl_w_nxt = (pwdata > 32'(sso_pkg::MAX_WIDTH)) ? sso_pkg::MAX_WIDTH
                                                          : pwdata[30:0];
        sso_pkg::OFS_NEAR_W:
          near_w_nxt = (pwdata > 32'(sso_pkg::MAX_WIDTH)) ? sso_pkg::MAX_WIDTH
                                                          : pwdata[30:0];
        sso_pkg::OFS_QUAL:
          qual_nxt = (pwdata[1:0] == 2'h3) ? qual_r : pwdata[1:0];
        sso_pkg::OFS_ALLOC_A: alloc_a_nxt = pwdata[15:0];
        sso_pkg::OFS_ALLOC_B: alloc_b_nxt = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rot_thr_r  <= sso_pkg::RST_ROT_THR;
      positioning_complete_win_r <= sso_pkg::RST_POSITIONING_COMPLETE_WIN;
      cmpl_w_r   <= sso_pkg::RST_CMPL_W;
      near_w_r   <= sso_pkg::RST_NEAR_W;
      qual_r     <= sso_pkg::RST_QUAL;
      alloc_a_r  <= sso_pkg::RST_ALLOC_A;
      alloc_b_r  <= sso_pkg::RST_ALLOC_B;
      prdata_r   <= 32'h00000000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end else begin
      rot_thr_r  <= rot_thr_nxt;
      positioning_complete_win_r <= positioning_complete_win_nxt;
      cmpl_w_r   <= cmpl_w_nxt;
      near_w_r   <= near_w_nxt;
      qual_r     <= qual_nxt;
      alloc_a_r  <= alloc_a_nxt;
      alloc_b_r  <= alloc_b_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  // Sample drive quantities once per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mspd_r  <= '0;
      cspd_r  <= '0;
      dev_r   <= '0;
      fz_r    <= 1'b0;
      rz_r    <= 1'b0;
      smode_r <= 1'b0;
      pmode_r <= 1'b0;
    end else begin
      mspd_r  <= motor_speed;
      cspd_r  <= cmd_speed;
      dev_r   <= pos_deviation;
      fz_r    <= filt_cmd_zero;
      rz_r    <= raw_cmd_zero;
      smode_r <= speed_mode;
      pmode_r <= position_mode;
    end
  end

  assign mspd_abs  = mspd_r[SPD_W-1] ? SPD_W'(-mspd_r) : SPD_W'(mspd_r);
  assign sdiff     = (SPD_W+1)'(mspd_r) - (SPD_W+1)'(cspd_r);
  assign sdiff_abs = sdiff[SPD_W] ? (SPD_W+1)'(-sdiff) : sdiff;
  assign dev_abs   = mag(dev_r);

  // Indication evaluation
  always_comb begin
    logic base_ok;
    logic in_w;
    base_ok    = 1'b0;
    in_w       = 1'b0;
    pole_nxt   = pole_r;
    pstart_nxt = 1'b0;
    case (pole_r)
      sso_pkg::PD_IDLE: begin
        if (servo_on_cmd) begin
          pole_nxt   = sso_pkg::PD_RUN;
          pstart_nxt = 1'b1;
        end
      end
      sso_pkg::PD_RUN:  if (pole_det_done) pole_nxt = sso_pkg::PD_DONE;
      sso_pkg::PD_DONE: pole_nxt = sso_pkg::PD_DONE;
      default:          pole_nxt = sso_pkg::PD_IDLE;
    endcase
    rot_nxt = ({{(32-SPD_W){1'b0}}, mspd_abs} > 32'(rot_thr_r));
    base_ok = main_power_on & ~base_block & ~alarm_active;
    if (abs_encoder) begin
      base_ok = base_ok & sensor_on_cmd & abs_data_sent;
    end
    // Before the first servo-on the pole condition is waived so servo-on can be accepted
    rdy_nxt  = base_ok & (pole_r != sso_pkg::PD_RUN);
    vcmp_nxt = smode_r &
               ({{(31-SPD_W){1'b0}}, sdiff_abs} < 32'(positioning_complete_win_r));
    in_w     = ({1'b0, dev_abs} < (POS_W+1)'(cmpl_w_r));
    case (sso_pkg::sso_qual_t'(qual_r))
      sso_pkg::QUAL_DEV:  positioning_complete_nxt = in_w;
      sso_pkg::QUAL_FILT: positioning_complete_nxt = in_w & fz_r;
      sso_pkg::QUAL_RAW:  positioning_complete_nxt = in_w & rz_r;
      default:            positioning_complete_nxt = in_w;
    endcase
    positioning_complete_nxt = positioning_complete_nxt & pmode_r;
    near_nxt = pmode_r & ({1'b0, dev_abs} < (POS_W+1)'(near_w_r));
    cont_nxt = route(alloc_a_r[sso_pkg::DIG_VCMP +: 4], vcmp_r)
             | route(alloc_a_r[sso_pkg::DIG_POSITIONING_COMPLETE +: 4], positioning_complete_r)
             | route(alloc_a_r[sso_pkg::DIG_RDY  +: 4], rdy_r)
             | route(alloc_a_r[sso_pkg::DIG_ROTATION_DETECTED +: 4], rot_r)
             | route(alloc_b_r[sso_pkg::DIG_NEAR +: 4], near_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pole_r   <= sso_pkg::PD_IDLE;
      pstart_r <= 1'b0;
      rot_r    <= 1'b0;
      rdy_r    <= 1'b0;
      vcmp_r   <= 1'b0;
      positioning_complete_r   <= 1'b0;
      near_r   <= 1'b0;
      cont_r   <= '0;
    end else begin
      pole_r   <= pole_nxt;
      pstart_r <= pstart_nxt;
      rot_r    <= rot_nxt;
      rdy_r    <= rdy_nxt;
      vcmp_r   <= vcmp_nxt;
      positioning_complete_r   <= positioning_complete_nxt;
      near_r   <= near_nxt;
      cont_r   <= cont_nxt;
    end
  end

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign pole_det_start       = pstart_r;
  assign rotation_detected    = rot_r;
  assign servo_ready          = rdy_r;
  assign speed_coincidence    = vcmp_r;
  assign positioning_complete = positioning_complete_r;
  assign near_position        = near_r;
  assign out_contact          = cont_r;

endmodule

/* File: sso_status_checker.sv */
// Concurrent checks on the servo status indications
module sso_status_checker #(
  parameter int SPD_W = 16,
  parameter int N_OUT = 8
) (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // Drive state
  input wire logic signed [SPD_W-1:0] motor_speed,
  input wire logic                    speed_mode,
  input wire logic                    position_mode,
  input wire logic                    main_power_on,
  input wire logic                    base_block,
  input wire logic                    alarm_active,
  input wire logic                    abs_encoder,
  input wire logic                    sensor_on_cmd,
  input wire logic                    abs_data_sent,
  input wire logic                    servo_on_cmd,
  // Indications
  input wire logic                    pole_det_start,
  input wire logic                    rotation_detected,
  input wire logic                    servo_ready,
  input wire logic                    speed_coincidence,
  input wire logic                    positioning_complete,
  input wire logic                    near_position,
  input wire logic [N_OUT-1:0]        out_contact
);
  timeunit 1ns;
  timeprecision 1ns;
  logic any_flag;
  assign any_flag = rotation_detected | servo_ready | speed_coincidence
                  | positioning_complete | near_position;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rot_speed: assert property (
    rotation_detected |-> $past(motor_speed, 2) != '0) else $error("rotation at zero speed");
  a_ready_gate: assert property (
    servo_ready |-> $past(main_power_on) && !$past(base_block) && !$past(alarm_active))
    else $error("ready without power or with block or alarm");
  a_ready_abs: assert property (
    servo_ready |-> !$past(abs_encoder) || ($past(sensor_on_cmd) && $past(abs_data_sent)))
    else $error("ready before encoder data delivered");
  a_pole_start: assert property (
    pole_det_start |-> $past(servo_on_cmd) ##1 !pole_det_start) else $error("bad pole start");
  a_vcmp_mode: assert property (
    speed_coincidence |-> $past(speed_mode, 2)) else $error("coincidence outside speed mode");
  a_positioning_complete_mode: assert property (
    positioning_complete |-> $past(position_mode, 2)) else $error("complete outside position");
  a_near_mode: assert property (
    near_position |-> $past(position_mode, 2)) else $error("near outside position mode");
  a_contact_cause: assert property (
    out_contact != '0 |-> $past(any_flag)) else $error("contact closed with no flag");
endmodule

bind sso_status sso_status_checker #(.SPD_W(SPD_W), .N_OUT(N_OUT)) chk (.pclk, .presetn,
  .motor_speed, .speed_mode, .position_mode, .main_power_on, .base_block, .alarm_active,
  .abs_encoder, .sensor_on_cmd, .abs_data_sent, .servo_on_cmd, .pole_det_start,
  .rotation_detected, .servo_ready, .speed_coincidence, .positioning_complete,
  .near_position, .out_contact);

/* File: sso_status_test.sv */
// Self-checking bench for the servo status outputs
module sso_status_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic [7:0] paddr = '0, out_contact;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic signed [15:0] motor_speed = '0, cmd_speed = '0;
  logic signed [31:0] pos_deviation = '0;
  logic filt_cmd_zero = 0, raw_cmd_zero = 0, speed_mode = 0, position_mode = 0;
  logic main_power_on = 0, base_block = 0, alarm_active = 0, abs_encoder = 0;
  logic sensor_on_cmd = 0, abs_data_sent = 0, pole_det_done = 0, want_on = 0;
  logic servo_on_cmd, pole_det_start, rotation_detected, servo_ready;
  logic speed_coincidence, positioning_complete, near_position;
  int num_errors = 0, tests_run = 0, cyc = 0, pstarts = 0;
  int thr = 20, win = 10, cw = 10, nw = 1073741824, q = 0, pst = 0;
  int offs[5] = '{-10, -9, 9, 10, 3};

  always #10 pclk = ~pclk;

  sso_status DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .motor_speed, .cmd_speed, .pos_deviation, .filt_cmd_zero,
    .raw_cmd_zero, .speed_mode, .position_mode, .main_power_on, .base_block, .alarm_active,
    .abs_encoder, .sensor_on_cmd, .abs_data_sent, .servo_on_cmd, .pole_det_done,
    .pole_det_start, .rotation_detected, .servo_ready, .speed_coincidence,
    .positioning_complete, .near_position, .out_contact);
  sso_host_model HOST (.pclk, .presetn, .want_on, .servo_ready, .servo_on_cmd);

  function automatic int iabs(input int x);
    return x < 0 ? -x : x;
  endfunction

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rdat, exp);
  endtask

  // Model of every indication except pole_det_start, and of every contact, from the current stimulus
  task automatic settle_check();
    logic r, v, c, n, y;
    logic [7:0] k;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    r = iabs(motor_speed) > thr;
    v = speed_mode && iabs(motor_speed - cmd_speed) < win;
    c = position_mode && iabs(pos_deviation) < cw
        && (q == 0 || (q == 1 && filt_cmd_zero) || (q == 2 && raw_cmd_zero));
    n = position_mode && iabs(pos_deviation) < nw;
    y = main_power_on && !base_block && !alarm_active && pst != 1
        && (!abs_encoder || (sensor_on_cmd && abs_data_sent));
    k = {2'b00, n, v, r, c, y, 1'b0};
    cmp({rotation_detected, servo_ready, speed_coincidence, positioning_complete,
         near_position}, {r, y, v, c, n});
    cmp(out_contact, k);
    @(posedge pclk);
  endtask

  // Count pole-detection start pulses where they are settled
  always @(negedge pclk) begin
    if (pole_det_start === 1'b1) pstarts++;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(4669));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 32'h14);
    rd(8'h08, 32'h0A);
    rd(8'h0C, 32'h0A);
    rd(8'h10, 32'h40000000);
    rd(8'h14, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    cmp(rerr, 1'b1);
    apb(1'b1, 8'h04, 32'h4E20);
    rd(8'h04, 32'h2710);
    apb(1'b1, 8'h04, 32'h64);
    thr = 100;
    apb(1'b1, 8'h18, 32'h4253);
    apb(1'b1, 8'h1C, 32'h6);
    for (int i = 0; i < 6; i++) begin
      motor_speed <= i < 3 ? 16'(99 + i) : 16'($urandom_range(400) - 200);
      settle_check();
    end
    speed_mode <= 1'b1;
    cmd_speed <= 16'sh3E8;
    for (int i = 0; i < 5; i++) begin
      motor_speed <= 16'(1000 + offs[i]);
      settle_check();
    end
    speed_mode <= 1'b0;
    settle_check();
    position_mode <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      q = m;
      apb(1'b1, 8'h14, 32'(m));
      for (int i = 0; i < 4; i++) begin
        pos_deviation <= i[1] ? 32'sh0A : -32'sh09;
        filt_cmd_zero <= i[0];
        raw_cmd_zero <= !i[0];
        settle_check();
      end
    end
    q = 0;
    apb(1'b1, 8'h14, 32'h0);
    nw = 5;
    apb(1'b1, 8'h10, 32'h5);
    cw = $urandom_range(50);
    apb(1'b1, 8'h0C, 32'(cw));
    for (int i = 0; i < 4; i++) begin
      pos_deviation <= 32'($urandom_range(120) - 60);
      settle_check();
    end
    position_mode <= 1'b0;
    settle_check();
    main_power_on <= 1'b1;
    settle_check();
    alarm_active <= 1'b1;
    settle_check();
    alarm_active <= 1'b0;
    abs_encoder <= 1'b1;
    sensor_on_cmd <= 1'b1;
    settle_check();
    abs_data_sent <= 1'b1;
    settle_check();
    want_on <= 1'b1;
    pst = 1;
    settle_check();
    cmp(servo_on_cmd, 1'b1);
    pole_det_done <= 1'b1;
    pst = 2;
    settle_check();
    base_block <= 1'b1;
    settle_check();
    rd(8'h20, 32'h21);
    cmp(pstarts, 1);
    tally_and_finish();
  end
endmodule
